/* logic/scsr_pkg.sv */
/*
  Constants, field layouts and carrier types of the socket command and
  event status register block.
  Assumes an 8-bit local host bus and four socket channels driven by a
  protocol engine on the same clock.
*/
// Overview of operation
// R1: Host never touches reserved locations nor writes read-only registers.
// R2: Channel-0 command bit 0 loads gateway, mask, hardware and IP address.
// R3: The system initialisation command also closes sockets on all channels.
// R4: Device clears each command bit itself once the operation is done.
// R5: Bit 1 opens the socket in the mode the channel option protocol selects.
// R6: Bit 2 makes the socket a client connecting to the remote server.
// R7: Bit 3 puts the socket in server mode awaiting a connection.
// R8: Bit 4 ends any connection and then closes the socket.
// R9: Bit 5 starts sending pending data; bit 6 performs the receive.
// R10: Channel-0 bit 7 is a software reset of internal settings.
// R11: Channel-1 bit 7 held one selects memory test mode; host clears it.
// R12: Channel-1 command: bit 0 reserved, bits 1 to 6 socket commands.
// R13: Channel 2 and 3 commands at 0x02, 0x03; bits 0 and 7 reserved.
// R14: A channel status register clears to zero when the host reads it.
// R15: Channel-0 status bit 0 flags system initialisation done.
// R16: Status bit 2 flags a connection established by connect or listen.
// R17: Status bit 4 flags timeout in connection set-up or send.
// R18: Status bits 1, 3, 5, 6 flag open, close, send, receive done.
// R19: Channel-0 status sits at 0x04 with bit 7 reserved.
// R20: Channel 1 to 3 status at 0x05 to 0x07, bits 0 and 7 reserved.
// R21: Summary register at 0x08 flags channels with pending status.
// R22: Host writes address configuration before system initialisation.
// R23: Reserved command and status bits read zero and ignore writes.
`default_nettype none

package scsr_pkg;

  localparam int NCH    = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_CMD_BASE  = 8'h00;
  localparam logic [7:0] OFS_STAT_BASE = 8'h04;
  localparam logic [7:0] OFS_SUMMARY   = 8'h08;

  // Command bit positions
  localparam int BIT_SYS_INIT  = 0;
  localparam int BIT_SOCK_OPEN = 1;
  localparam int BIT_CONNECT   = 2;
  localparam int BIT_LISTEN    = 3;
  localparam int BIT_CLOSE     = 4;
  localparam int BIT_SEND      = 5;
  localparam int BIT_RECV      = 6;
  localparam int BIT_TOP       = 7;

  // Implemented bits per channel
  localparam logic [7:0] CMD_MASK_CH0  = 8'h7f;
  localparam logic [7:0] CMD_MASK_CH1  = 8'h7e;
  localparam logic [7:0] CMD_MASK_CHN  = 8'h7e;
  localparam logic [7:0] STAT_MASK_CH0 = 8'h7f;
  localparam logic [7:0] STAT_MASK_CHN = 8'h7e;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  // Engine events; bit order matches the status register layout
  typedef struct packed {
    logic recv_ok;
    logic send_ok;
    logic timeout;
    logic closed;
    logic established;
    logic socket_open_done;
    logic init_ok;
  } scsr_evt_t;

  // Host bus strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } scsr_strb_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } scsr_bus_st_t;

endpackage : scsr_pkg

`default_nettype wire

/* logic/scsr_regs.sv */
/*
  Socket command and event status registers: four self-clearing command
  registers, four clear-on-read status registers and a channel summary.
  Assumes the host bus pins are asynchronous to core_clk_i, hold address
  and data stable throughout each strobe and for two clocks after it, and that strobes last at least
  three clocks; the protocol engine shares the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module scsr_regs #(
  parameter int NCH    = scsr_pkg::NCH,
  parameter int ADDR_W = scsr_pkg::ADDR_W
) (
  // Clock and reset
  input  wire  logic                       core_clk_i,
  input  wire  logic                       rst_i,
  // Host local bus
  input  wire  logic                       bus_cs_n_i,
  input  wire  logic                       bus_rd_n_i,
  input  wire  logic                       bus_wr_n_i,
  input  wire  logic [ADDR_W-1:0]          bus_addr_i,
  input  wire  logic [7:0]                 bus_data_i,
  output logic       [7:0]                 bus_data_o,
  output logic                             bus_data_oe_n_o,
  // Protocol engine
  output logic       [NCH-1:0][7:0]        cmd_o,
  input  wire  logic [NCH-1:0][7:0]        cmd_done_i,
  input  wire  scsr_pkg::scsr_evt_t [NCH-1:0] evt_i,
  input  wire  logic [NCH-1:0]             rx_data_i,
  output logic                             mem_test_o,
  output logic                             soft_reset_o
);

  localparam int IDX_W = (NCH > 1) ? $clog2(NCH) : 1;

  scsr_pkg::scsr_strb_t    strb_s1_q;
  scsr_pkg::scsr_strb_t    strb_s2_q;
  logic [ADDR_W-1:0]       addr_s1_q;
  logic [ADDR_W-1:0]       addr_s2_q;
  logic [7:0]              data_s1_q;
  logic [7:0]              data_s2_q;
  scsr_pkg::scsr_bus_st_t  st_q;
  scsr_pkg::scsr_bus_st_t  st_d;
  logic [NCH-1:0][7:0]     cmd_q;
  logic [NCH-1:0][7:0]     stat_q;
  logic [NCH-1:0]          rx_q;
  logic [7:0]              rdata;
  logic                    wr_done;
  logic                    rd_done;
  logic                    sel_cmd;
  logic                    sel_stat;
  logic                    sel_sum;
  logic [IDX_W-1:0]        idx;
  logic                    sys_init_wr;
  logic                    sw_rst_wr;

  // Pins pass two flip-flops before any decode looks at them
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strb_s1_q <= '1;
      strb_s2_q <= '1;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= scsr_pkg::RESET_BYTE;
      data_s2_q <= scsr_pkg::RESET_BYTE;
    end else begin
      strb_s1_q <= '{cs_n: bus_cs_n_i, rd_n: bus_rd_n_i, wr_n: bus_wr_n_i};
      strb_s2_q <= strb_s1_q;
      addr_s1_q <= bus_addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= bus_data_i;
      data_s2_q <= data_s1_q;
    end
  end

  // Address decode
  always_comb begin
    sel_cmd  = 1'b0;
    sel_stat = 1'b0;
    sel_sum  = 1'b0;
    if (addr_s2_q < ADDR_W'(scsr_pkg::OFS_STAT_BASE)) begin
      sel_cmd = 1'b1;
    end else if (addr_s2_q < ADDR_W'(scsr_pkg::OFS_SUMMARY)) begin
      sel_stat = 1'b1;
    end else if (addr_s2_q == ADDR_W'(scsr_pkg::OFS_SUMMARY)) begin
      sel_sum = 1'b1;
    end
  end

  assign idx = addr_s2_q[IDX_W-1:0];

  // Bus sequencer: act on the trailing edge of each strobe
  always_comb begin
    st_d = st_q;
    case (st_q)
      scsr_pkg::ST_IDLE: begin
        if (!strb_s2_q.cs_n && !strb_s2_q.wr_n) begin
          st_d = scsr_pkg::ST_WRITE;
        end else if (!strb_s2_q.cs_n && !strb_s2_q.rd_n) begin
          st_d = scsr_pkg::ST_READ;
        end
      end
      scsr_pkg::ST_WRITE: begin
        if (strb_s2_q.wr_n) begin
          st_d = scsr_pkg::ST_IDLE;
        end
      end
      scsr_pkg::ST_READ: begin
        if (strb_s2_q.rd_n || strb_s2_q.cs_n) begin
          st_d = scsr_pkg::ST_IDLE;
        end
      end
      default: st_d = scsr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= scsr_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign wr_done = (st_q == scsr_pkg::ST_WRITE) && strb_s2_q.wr_n;
  assign rd_done = (st_q == scsr_pkg::ST_READ) && (st_d == scsr_pkg::ST_IDLE);
  assign sys_init_wr = wr_done && sel_cmd && (idx == '0)
                       && data_s2_q[scsr_pkg::BIT_SYS_INIT];
  assign sw_rst_wr = wr_done && sel_cmd && (idx == '0)
                     && data_s2_q[scsr_pkg::BIT_TOP];

  // Read data: reserved bits and unmapped offsets read zero
  always_comb begin
    rdata = scsr_pkg::RESET_BYTE;
    if (sel_cmd) begin
      rdata = cmd_q[idx];
    end else if (sel_stat) begin
      rdata = stat_q[idx];
    end else if (sel_sum) begin
      for (int c = 0; c < NCH; c++) begin
        rdata[c]       = |stat_q[c]; // R21
        rdata[c + NCH] = rx_q[c];
      end
    end
  end

  // Data pins are driven while the synchronised read strobe is held, three clocks behind the pins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_data_o      <= scsr_pkg::RESET_BYTE;
      bus_data_oe_n_o <= 1'b1;
    end else if (st_d == scsr_pkg::ST_READ) begin
      bus_data_o      <= rdata;
      bus_data_oe_n_o <= 1'b0;
    end else begin
      bus_data_oe_n_o <= 1'b1;
    end
  end

  // Software reset pulse to the rest of the device
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= sw_rst_wr; // R10
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      localparam logic [7:0] CMASK = (ch == 0) ? scsr_pkg::CMD_MASK_CH0 :
        (ch == 1) ? scsr_pkg::CMD_MASK_CH1 : scsr_pkg::CMD_MASK_CHN;
      localparam logic [7:0] SMASK = (ch == 0) ? scsr_pkg::STAT_MASK_CH0 :
        scsr_pkg::STAT_MASK_CHN;
      logic [7:0] cmd_d;
      logic [7:0] stat_d;
      logic       hit;

      assign hit = (idx == IDX_W'(ch));

      // Command bits 0 to 6 stay set until the engine reports completion
      always_comb begin
        cmd_d = cmd_q[ch] & ~(cmd_done_i[ch] & CMASK); // R4
        if (wr_done && sel_cmd && hit) begin
          cmd_d = cmd_d | (data_s2_q & CMASK); // R2 R5 R6 R7 R8 R9 R12 R13 R23
        end
        if (sys_init_wr) begin
          cmd_d[scsr_pkg::BIT_CLOSE] = 1'b1; // R3
        end
        if (ch == 1 && wr_done && sel_cmd && hit) begin
          cmd_d[scsr_pkg::BIT_TOP] = data_s2_q[scsr_pkg::BIT_TOP]; // R11
        end
      end

      // Read clears only the bits of the last byte driven on bus_data_o, so a later event survives
      always_comb begin
        stat_d = stat_q[ch];
        if (rd_done && sel_stat && hit) begin
          stat_d = stat_d & ~bus_data_o; // R14
        end
        stat_d = stat_d | ({1'b0, evt_i[ch]} & SMASK); // R15 R16 R17 R18 R19 R20
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cmd_q[ch] <= scsr_pkg::RESET_BYTE;
        end else if (sw_rst_wr) begin
          cmd_q[ch] <= scsr_pkg::RESET_BYTE; // R10
        end else begin
          cmd_q[ch] <= cmd_d;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          stat_q[ch] <= scsr_pkg::RESET_BYTE;
        end else if (sw_rst_wr) begin
          stat_q[ch] <= scsr_pkg::RESET_BYTE; // R10
        end else begin
          stat_q[ch] <= stat_d;
        end
      end

      // Data receipt flags clear by writing one; a new receipt wins
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          rx_q[ch] <= 1'b0;
        end else if (sw_rst_wr) begin
          rx_q[ch] <= 1'b0;
        end else if (rx_data_i[ch]) begin
          rx_q[ch] <= 1'b1;
        end else if (wr_done && sel_sum && data_s2_q[ch + NCH]) begin
          rx_q[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  assign cmd_o      = cmd_q;
  assign mem_test_o = cmd_q[1][scsr_pkg::BIT_TOP]; // R11

endmodule : scsr_regs

`default_nettype wire

/* sim/scsr_checker.sv */
/* Assertions on the scsr_regs ports, bound to every instance.
   Assumes a host that holds the address through each read window. */
`timescale 1ns/1ps
`default_nettype none
module scsr_checker #(
  parameter int NCH    = scsr_pkg::NCH,
  parameter int ADDR_W = scsr_pkg::ADDR_W
) (
  // Watched ports
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic                bus_rd_n_i,
  input wire logic                bus_wr_n_i,
  input wire logic [ADDR_W-1:0]   bus_addr_i,
  input wire logic [7:0]          bus_data_o,
  input wire logic                bus_data_oe_n_o,
  input wire logic [NCH-1:0][7:0] cmd_o,
  input wire logic [NCH-1:0][7:0] cmd_done_i,
  input wire logic                soft_reset_o
);
  // Write actions land clocks after the strobe, so wait them out
  logic [2:0] idle_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) idle_q <= 3'h0;
    else if (!bus_wr_n_i) idle_q <= 3'h0;
    else if (idle_q != 3'h7) idle_q <= idle_q + 3'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_resv_ch1: assert property (!cmd_o[1][0])
    else $error("ch1 reserved bit set");
  a_resv_ch23: assert property (
    !(cmd_o[2][0] | cmd_o[2][7] | cmd_o[3][0] | cmd_o[3][7]))
    else $error("ch2/3 reserved bit set");
  a_done_clears: assert property (idle_q == 3'h7 |=>
    (cmd_o & $past(cmd_done_i) & 32'h7e7e7e7e) == 32'h0)
    else $error("command bit survived completion");
  a_sinit_closes: assert property ($rose(cmd_o[0][0]) |->
    cmd_o[0][4] && cmd_o[1][4] && cmd_o[2][4] && cmd_o[3][4])
    else $error("init left a socket open");
  a_reset_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  a_read_drive: assert property (
    $fell(bus_rd_n_i) |-> ##[2:4] !bus_data_oe_n_o)
    else $error("read data not driven");
  a_read_release: assert property (
    $rose(bus_rd_n_i) |-> ##[2:4] bus_data_oe_n_o)
    else $error("read data driven too long");
  a_stat_resv: assert property (
    !bus_data_oe_n_o && bus_addr_i inside {[8'h04:8'h07]} |->
    !bus_data_o[7] && (bus_addr_i == 8'h04 || !bus_data_o[0]))
    else $error("reserved status bit set");
  a_unmapped_zero: assert property (
    !bus_data_oe_n_o && bus_addr_i > 8'h08 |-> bus_data_o == 8'h00)
    else $error("unmapped read not zero");
  c_sinit: cover property ($rose(cmd_o[0][0]));
  c_mem_test: cover property ($rose(cmd_o[1][7]));
  c_soft_reset: cover property (soft_reset_o);
endmodule // scsr_checker
bind scsr_regs scsr_checker #(.NCH(NCH), .ADDR_W(ADDR_W)) u_chk (
  .core_clk_i, .rst_i, .bus_rd_n_i, .bus_wr_n_i, .bus_addr_i, .bus_data_o,
  .bus_data_oe_n_o, .cmd_o, .cmd_done_i, .soft_reset_o);
`default_nettype wire

/* sim/scsr_host.sv */
/* Host microcontroller model on the local bus of scsr_regs.
   Assumes the bench calls cyc for each byte-wide access. */
`timescale 1ns/1ps
`default_nettype none
module scsr_host (
  // Clock and read return
  input  wire logic           clk_i,
  input  wire logic [7:0]     rdata_i,
  input  wire logic           oe_n_i,
  // Bus pins
  output var scsr_pkg::scsr_strb_t strb_o,
  output logic [7:0]          addr_o,
  output logic [7:0]          data_o
);
  initial begin
    strb_o = 3'b111;
    addr_o = 8'h00;
    data_o = 8'h00;
  end
  // Address leads the strobe and outlives it so every sync stage sees it
  // settled; strobes last four clocks, gaps six
  task automatic cyc(input logic [7:0] a, input logic [7:0] d,
                     input logic wr, output logic [7:0] q);
    addr_o = a;
    data_o = d;
    @(posedge clk_i);
    #1 strb_o = wr ? 3'b010 : 3'b001;
    repeat (4) @(posedge clk_i);
    #1 q = (oe_n_i === 1'b0) ? rdata_i : 8'hxx;
    strb_o = 3'b111;
    repeat (4) @(posedge clk_i);
    #1 data_o = ~d; // Released pins must not look like live data
    @(posedge clk_i);
    #1;
  endtask
endmodule // scsr_host
`default_nettype wire

/* sim/test_socket_command_status_regs.sv */
/* Self-checking bench for scsr_regs: host model on the bus, engine
   pulses from here. Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module test_socket_command_status_regs;
  logic                      core_clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  scsr_pkg::scsr_strb_t      strb;
  logic [7:0]                addr, wdata, rdata, r, rxacc;
  logic                      oe_n, mem_test, swr;
  logic [3:0][7:0]           cmd, done;
  scsr_pkg::scsr_evt_t [3:0] evt;
  logic [3:0]                rx;
  int                        n_mismatch = 0;
  int                        cmp_count = 0;
  int                        n_swr = 0;

  always #10 core_clk_i = ~core_clk_i;

  // Counts soft reset pulses so the bench sees exactly one per command
  always @(posedge core_clk_i) begin
    if (swr === 1'b1) n_swr++;
  end

  scsr_regs DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_cs_n_i(strb.cs_n),
    .bus_rd_n_i(strb.rd_n), .bus_wr_n_i(strb.wr_n), .bus_addr_i(addr),
    .bus_data_i(wdata), .bus_data_o(rdata), .bus_data_oe_n_o(oe_n),
    .cmd_o(cmd), .cmd_done_i(done), .evt_i(evt), .rx_data_i(rx),
    .mem_test_o(mem_test), .soft_reset_o(swr));
  scsr_host H (
    .clk_i(core_clk_i), .rdata_i(rdata), .oe_n_i(oe_n), .strb_o(strb),
    .addr_o(addr), .data_o(wdata));

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    if (a < 8'h04 || a == 8'h08) H.cyc(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] q;
    H.cyc(a, 8'h00, 1'b0, q);
    chk(q, x);
  endtask
  task automatic pulse(input logic [31:0] dn, input logic [27:0] ev,
                       input logic [3:0] rv);
    @(posedge core_clk_i);
    #1 done = dn;
    evt = ev;
    rx = rv;
    @(posedge core_clk_i);
    #1 done = '0;
    evt = '0;
    rx = '0;
  endtask
  // Status bit 0 exists on channel 0 only
  function automatic logic [7:0] smask(input int c);
    return (c == 0) ? 8'h7f : 8'h7e;
  endfunction
  task tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    done = '0;
    evt = '0;
    rx = '0;
    rxacc = 8'h00;
    void'($urandom(32'h1ded));
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    for (int a = 0; a < 9; a++) rd(8'(a), 8'h00);
    rd(8'h20, 8'h00);
    for (int c = 0; c < 4; c++) begin
      r = 8'($urandom());
      wr(8'(c), c == 0 ? r & 8'h7e : c == 1 ? r & 8'h7f : r);
      chk(cmd[c], r & 8'h7e);
      rd(8'(c), r & 8'h7e);
      pulse(32'hff << (8 * c), '0, '0);
      rd(8'(c), 8'h00);
      r = 8'($urandom()) | 8'h02;
      pulse('0, 28'(r[6:0]) << (7 * c), 4'(1 << c));
      rxacc = rxacc | (8'h10 << c);
      rd(8'h08, rxacc | 8'(1 << c));
      rd(8'(4 + c), r & smask(c));
      rd(8'(4 + c), 8'h00);
    end
    wr(8'h08, 8'h30);
    rd(8'h08, 8'hc0);
    // Address configuration sits outside this block and is taken as loaded
    wr(8'h00, 8'h01);
    for (int c = 0; c < 4; c++) rd(8'(c), c == 0 ? 8'h11 : 8'h10);
    wr(8'h01, 8'h80);
    chk({7'h00, mem_test}, 8'h01);
    wr(8'h01, 8'h00);
    chk({7'h00, mem_test}, 8'h00);
    pulse('0, 28'h4200000, 4'h8);
    rd(8'h07, 8'h20);
    pulse('0, 28'h4000000, 4'h8);
    wr(8'h00, 8'h80);
    chk(8'(n_swr), 8'h01);
    rd(8'h02, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    tally_and_finish;
  end
endmodule // test_socket_command_status_regs
`default_nettype wire
